//--- rtl/pvs_pcm_slot.sv
// Slotted PCM voice interface, master or slave, with firmware register port
`timescale 1ns/10ps
module pvs_pcm_slot (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Firmware register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Bit clock pin
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  // Frame sync pin
  input wire logic fsync_i,
  output logic fsync_o,
  output logic fsync_oe,
  // Serial data pins
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HUNT,
    ST_RUN
  } pvs_state_e;

  pvs_pkg::pvs_ctrl_s ctrl_q;
  pvs_pkg::pvs_slot_s slot_q;
  pvs_pkg::pvs_fmt_s fmt_q;
  logic [7:0] div_q;
  logic [2:0][15:0] tx_q;
  logic [2:0][15:0] rx_q;
  logic [2:0] rx_full_q;
  logic [2:0] tx_taken_q;
  logic [7:0] frame_cnt_q;
  logic [31:0] rdata_q;

  pvs_state_e state_q;
  logic [7:0] div_cnt_q;
  logic bclk_q;
  logic bclk_oe_q;
  logic fsync_q;
  logic fsync_oe_q;
  logic sync_prev_q;
  logic [7:0] bit_q;
  logic [15:0] cur_q;
  logic [15:0] rx_sh_q;
  logic dout_q;
  logic dout_oe_q;

  logic s_rise;
  logic s_fall;
  logic [1:0] dat_s;
  logic sync_s;
  logic din_s;
  logic active;
  logic run;
  logic tog;
  logic rise_ev;
  logic fall_ev;
  logic [7:0] half;
  logic [2:0] code;
  logic [7:0] frame_last;
  logic [7:0] nb;
  logic [2:0] own_tx;
  logic [2:0] own_rx;
  logic [15:0] tx_word;
  logic [15:0] sh_d;
  logic [2:0] rx_set;
  logic [2:0] tx_set;
  logic [2:0] rx_clr;
  logic [2:0] tx_clr;

  // Owner of a slot: {hit, channel}; lowest channel wins a clash
  function automatic logic [2:0] slot_owner(
    input logic [3:0] s,
    input pvs_pkg::pvs_slot_s c
  );
    logic [2:0] r;
    r = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (c.ch_en[i] && c.slot[i] == s) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // Sample to slot word on transmit
  function automatic logic [15:0] build_word(
    input logic [15:0] s,
    input pvs_pkg::pvs_ctrl_s c,
    input pvs_pkg::pvs_fmt_s f
  );
    logic [2:0] fill;
    fill = 3'h0;
    case (f.fill_mode)
      pvs_pkg::PVS_FILL_ONE: fill = 3'h7;
      pvs_pkg::PVS_FILL_SIGN: fill = {3{s[12]}};
      pvs_pkg::PVS_FILL_PROG: fill = f.fill_val;
      default: fill = 3'h0;
    endcase
    if (c.mode != pvs_pkg::PVS_NARROW) begin
      return s;
    end
    return c.right_just ? {fill, s[12:0]} : {s[12:0], fill};
  endfunction

  // Slot word to sign-extended sample on receive; fill bits dropped
  function automatic logic [15:0] take_word(
    input logic [15:0] w,
    input pvs_pkg::pvs_ctrl_s c
  );
    if (c.mode != pvs_pkg::PVS_NARROW) begin
      return w;
    end
    return c.right_just ? {{3{w[12]}}, w[12:0]} : {{3{w[15]}}, w[15:3]};
  endfunction

  // Pin inputs pass two flip-flops before use
  pvs_sync_edge #(
    .W(1)
  ) u_bclk_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d(bclk_i),
    .q(),
    .rise(s_rise),
    .fall(s_fall)
  );

  pvs_sync_edge #(
    .W(2)
  ) u_dat_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({fsync_i, din_i}),
    .q(dat_s),
    .rise(),
    .fall()
  );

  assign sync_s = dat_s[1];
  assign din_s = dat_s[0];

  // Pins count as owned only when not lent to the I2S function
  assign active = ctrl_q.enable & ctrl_q.pins_own;
  assign run = (state_q == ST_RUN);

  always_comb begin
    code = (slot_q.count_code > pvs_pkg::MAX_CODE) ?
      pvs_pkg::MAX_CODE : slot_q.count_code;
    frame_last = 8'((32'd16 << code) - 32'd1);
    nb = (bit_q == frame_last) ? 8'h00 : bit_q + 8'h01;
    if (ctrl_q.burst) begin
      half = pvs_pkg::BURST_HALF;
    end else if (div_q < pvs_pkg::MIN_HALF) begin
      half = pvs_pkg::MIN_HALF;
    end else begin
      half = div_q;
    end
    tog = active & ctrl_q.master & (div_cnt_q >= half - 8'h01);
    rise_ev = ctrl_q.master ? (tog & ~bclk_q) : (s_rise & active);
    fall_ev = ctrl_q.master ? (tog & bclk_q) : (s_fall & active);
    own_tx = slot_owner(nb[7:4], slot_q);
    own_rx = slot_owner(bit_q[7:4], slot_q);
    tx_word = (nb[3:0] == 4'h0) ?
      build_word(tx_q[own_tx[1:0]], ctrl_q, fmt_q) : cur_q;
    sh_d = ctrl_q.lsb_first ? {din_s, rx_sh_q[15:1]} :
      {rx_sh_q[14:0], din_s};
  end

  // Firmware configuration writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= pvs_pkg::CTRL_RST;
      slot_q <= pvs_pkg::SLOT_RST;
      fmt_q <= pvs_pkg::FMT_RST;
      div_q <= pvs_pkg::DIV_RST;
      tx_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        pvs_pkg::ADDR_CTRL: begin
          ctrl_q <= pvs_pkg::pvs_ctrl_s'(reg_wdata[8:0]);
        end
        pvs_pkg::ADDR_SLOT: begin
          slot_q <= pvs_pkg::pvs_slot_s'(reg_wdata[17:0]);
        end
        pvs_pkg::ADDR_FMT: begin
          fmt_q <= pvs_pkg::pvs_fmt_s'(reg_wdata[4:0]);
        end
        pvs_pkg::ADDR_DIV: begin
          div_q <= reg_wdata[7:0];
        end
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (reg_addr == 4'(pvs_pkg::ADDR_TX0 + i)) begin
              tx_q[i] <= reg_wdata[15:0];
            end
          end
        end
      endcase
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_comb begin
    rx_clr = 3'h0;
    tx_clr = 3'h0;
    if (reg_wr && reg_addr == pvs_pkg::ADDR_STAT) begin
      rx_clr = reg_wdata[pvs_pkg::STAT_RX_LSB +: 3];
      tx_clr = reg_wdata[pvs_pkg::STAT_TX_LSB +: 3];
    end
    rx_set = 3'h0;
    tx_set = 3'h0;
    if (fall_ev && run && own_rx[2] && bit_q[3:0] == pvs_pkg::LAST_POS) begin
      rx_set[own_rx[1:0]] = 1'b1;
    end
    if (rise_ev && run && own_tx[2] && nb[3:0] == 4'h0) begin
      tx_set[own_tx[1:0]] = 1'b1;
    end
  end

  // Flags let firmware match sample rates in slave transparent mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_q <= 3'h0;
      tx_taken_q <= 3'h0;
    end else begin
      rx_full_q <= (rx_full_q & ~rx_clr) | rx_set;
      tx_taken_q <= (tx_taken_q & ~tx_clr) | tx_set;
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (!reg_rd) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        pvs_pkg::ADDR_CTRL: rdata_q <= 32'(ctrl_q);
        pvs_pkg::ADDR_SLOT: rdata_q <= 32'(slot_q);
        pvs_pkg::ADDR_FMT: rdata_q <= 32'(fmt_q);
        pvs_pkg::ADDR_DIV: rdata_q <= 32'(div_q);
        4'h4: rdata_q <= 32'(tx_q[0]);
        4'h5: rdata_q <= 32'(tx_q[1]);
        4'h6: rdata_q <= 32'(tx_q[2]);
        4'h7: rdata_q <= 32'(rx_q[0]);
        4'h8: rdata_q <= 32'(rx_q[1]);
        4'h9: rdata_q <= 32'(rx_q[2]);
        pvs_pkg::ADDR_STAT: begin
          rdata_q <= {16'h0000, frame_cnt_q, 2'h0, tx_taken_q, rx_full_q};
        end
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Master bit clock divider
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 8'h00;
      bclk_q <= 1'b0;
    end else if (!(active && ctrl_q.master)) begin
      div_cnt_q <= 8'h00;
      bclk_q <= 1'b0;
    end else if (tog) begin
      div_cnt_q <= 8'h00;
      bclk_q <= ~bclk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // Pin drivers for clock and sync in master mode only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bclk_oe_q <= 1'b0;
      fsync_oe_q <= 1'b0;
    end else begin
      bclk_oe_q <= active & ctrl_q.master;
      fsync_oe_q <= active & ctrl_q.master;
    end
  end

  // Frame lock: master runs at once, slave waits for a sync
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (active) begin
            state_q <= ctrl_q.master ? ST_RUN : ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (!active) begin
            state_q <= ST_IDLE;
          end else if (fall_ev && sync_s) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!active) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Bit position in the frame; slave realigns on every sync
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 8'hFF;
      sync_prev_q <= 1'b0;
    end else if (!active) begin
      bit_q <= frame_last;
      sync_prev_q <= 1'b0;
    end else if (fall_ev && !ctrl_q.master) begin
      sync_prev_q <= sync_s;
      if (sync_s && !ctrl_q.long_sync) begin
        bit_q <= frame_last;
      end else if (sync_s && !sync_prev_q) begin
        bit_q <= 8'h00;
      end
    end else if (rise_ev) begin
      bit_q <= nb;
    end
  end

  // Master frame sync, short or long
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fsync_q <= 1'b0;
      frame_cnt_q <= 8'h00;
    end else if (!(active && ctrl_q.master)) begin
      fsync_q <= 1'b0;
    end else if (rise_ev) begin
      if (ctrl_q.long_sync) begin
        fsync_q <= (nb < pvs_pkg::LONG_SYNC_BITS);
      end else begin
        fsync_q <= (nb == frame_last);
      end
      if (nb == 8'h00) begin
        frame_cnt_q <= frame_cnt_q + 8'h01;
      end
    end
  end

  // Transmit: launch on rising edge, release after last falling edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= 16'h0000;
      dout_q <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (!active) begin
      dout_oe_q <= 1'b0;
    end else if (rise_ev) begin
      cur_q <= tx_word;
      dout_q <= ctrl_q.lsb_first ? tx_word[nb[3:0]] :
        tx_word[pvs_pkg::LAST_POS - nb[3:0]];
      dout_oe_q <= run & own_tx[2];
    end else if (fall_ev && bit_q[3:0] == pvs_pkg::LAST_POS) begin
      dout_oe_q <= 1'b0;
    end
  end

  // Receive: sample on falling edge in the channel's own slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q <= 16'h0000;
      rx_q <= '0;
    end else if (fall_ev && run && own_rx[2]) begin
      rx_sh_q <= sh_d;
      if (bit_q[3:0] == pvs_pkg::LAST_POS) begin
        rx_q[own_rx[1:0]] <= take_word(sh_d, ctrl_q);
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign bclk_o = bclk_q;
  assign bclk_oe = bclk_oe_q;
  assign fsync_o = fsync_q;
  assign fsync_oe = fsync_oe_q;
  assign dout_o = dout_q;
  assign dout_oe = dout_oe_q;

  a_clk_drive_master: assert property (
    @(posedge clock) disable iff (!rst_n)
    bclk_oe |-> $past(ctrl_q.master))
    else $error("bit clock driven outside master mode");

  a_idle_slot_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rise_ev && !own_tx[2]) |=> !dout_oe)
    else $error("data driven in an unowned slot");

  a_last_bit_release: assert property (
    @(posedge clock) disable iff (!rst_n)
    (fall_ev && bit_q[3:0] == 4'hF) |=> !dout_oe)
    else $error("data not released after last bit");

  a_short_sync_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rise_ev && active && ctrl_q.master && !ctrl_q.long_sync)
    |=> fsync_o == (bit_q == $past(frame_last)))
    else $error("short sync not one bit before slot zero");

  a_long_sync_end: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rise_ev && active && ctrl_q.master && ctrl_q.long_sync &&
     nb == 8'h03) |=> !fsync_o)
    else $error("long sync not three bits long");

  a_slave_short_lock: assert property (
    @(posedge clock) disable iff (!rst_n)
    (fall_ev && active && !ctrl_q.master && !ctrl_q.long_sync && sync_s)
    |=> bit_q == $past(frame_last))
    else $error("slave did not align slot zero to sync");

  a_frame_wrap_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rise_ev && active && bit_q == frame_last) |=> bit_q == 8'h00)
    else $error("frame did not wrap to bit zero");

  a_sign_fill_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ctrl_q.mode == pvs_pkg::PVS_NARROW && !ctrl_q.right_just &&
     fmt_q.fill_mode == pvs_pkg::PVS_FILL_SIGN && nb[3:0] == 4'h0)
    |-> tx_word[2:0] == {3{tx_word[15]}})
    else $error("sign fill bits wrong");

  a_burst_half_rate: assert property (
    @(posedge clock) disable iff (!rst_n)
    (tog && ctrl_q.burst) |-> div_cnt_q == 8'h02)
    else $error("burst clock period wrong");

  a_unmapped_read_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    (reg_rd && reg_addr > 4'hA) |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule

//--- rtl/pvs_pkg.sv
// Package for the PCM voice slot interface: register map, fields, timing
// Summary of operation
// - Master drives bit clock and frame sync; slave takes both as inputs
// - Two independent interfaces exist, each sharing its pins with I2S
// - Up to three full-duplex voice channels share one bus by slot
// - Each 8 or 16 kHz sample interval holds at most 16 slots
// - Slot count follows the interface rate: 1, 2, 4, 8 or 16 slots
// - A channel transmits and receives in the same slot number
// - Data output is released during slots no active channel owns
// - Data output releases after the falling clock edge of the last bit
// - Short or long frame sync selectable in master and slave mode
// - Short sync: one-bit high pulse per frame, on a rising clock edge
// - Short-sync slave samples sync on a fall; slot 0 starts next rise
// - Long sync: three-bit high pulse starting with slot zero's first bit
// - Narrowband uses 13 of 16 bits, position and order configurable
// - Unused bits ignored on receive; filled with 0, 1, sign or value
// - Default: 13-bit two's complement, left-justified, MSB first
// - Transparent wideband: 16-bit samples, typically master at 4 kHz sync
// - Transparent mode also works as slave, with rate matching by software
// - Codec mode carries linear 16-bit samples at 16 kHz frame rate
// - A host command starts burst mode with bit clock up to 24 MHz
// - All settings are written by host firmware, not mapped registers; here they sit in a register map on the firmware port
package pvs_pkg;

  typedef enum logic [1:0] {
    PVS_NARROW,
    PVS_WIDEBAND,
    PVS_CODEC,
    PVS_MODE_RSVD
  } pvs_mode_e;

  typedef enum logic [1:0] {
    PVS_FILL_ZERO,
    PVS_FILL_ONE,
    PVS_FILL_SIGN,
    PVS_FILL_PROG
  } pvs_fill_e;

  typedef struct packed {
    logic pins_own;
    pvs_mode_e mode;
    logic right_just;
    logic lsb_first;
    logic burst;
    logic long_sync;
    logic master;
    logic enable;
  } pvs_ctrl_s;

  typedef struct packed {
    logic [2:0][3:0] slot;
    logic [2:0] ch_en;
    logic [2:0] count_code;
  } pvs_slot_s;

  typedef struct packed {
    logic [2:0] fill_val;
    pvs_fill_e fill_mode;
  } pvs_fmt_s;

  // Register indices on the firmware port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SLOT = 4'h1;
  localparam logic [3:0] ADDR_FMT = 4'h2;
  localparam logic [3:0] ADDR_DIV = 4'h3;
  localparam logic [3:0] ADDR_TX0 = 4'h4;
  localparam logic [3:0] ADDR_RX0 = 4'h7;
  localparam logic [3:0] ADDR_STAT = 4'hA;

  localparam pvs_ctrl_s CTRL_RST = '0;
  localparam pvs_slot_s SLOT_RST = '0;
  localparam pvs_fmt_s FMT_RST = '0;
  localparam logic [7:0] DIV_RST = 8'h08;

  // Status fields
  localparam int STAT_RX_LSB = 0;
  localparam int STAT_TX_LSB = 3;
  localparam int STAT_FRM_LSB = 8;

  // Timing, in picoseconds, and cycle counts at the system clock
  localparam int CLK_PS = 10000;
  localparam int BCLK_LOW_PS = 41000;
  localparam int BURST_LOW_PS = 20800;
  localparam logic [7:0] MIN_HALF = 8'((BCLK_LOW_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] BURST_HALF =
    8'((BURST_LOW_PS + CLK_PS - 1) / CLK_PS);

  localparam logic [7:0] LONG_SYNC_BITS = 8'h03;
  localparam logic [2:0] MAX_CODE = 3'h4;
  localparam logic [3:0] LAST_POS = 4'hF;

endpackage

//--- rtl/pvs_sync_edge.sv
// Two-stage input synchroniser with edge detection
`timescale 1ns/10ps
module pvs_sync_edge #(
  parameter int W = 1
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous inputs
  input wire logic [W-1:0] d,
  // Synchronised levels and one-cycle edge pulses
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] q_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= d;
      q_q <= meta_q;
      prev_q <= q_q;
    end
  end

  assign q = q_q;
  assign rise = q_q & ~prev_q;
  assign fall = ~q_q & prev_q;

endmodule

//--- sim/pvs_codec_model.sv
// Codec or external PCM master facing the voice slot interface
`timescale 1ns/10ps
module pvs_codec_model (
  // Bench control
  input wire logic gen,
  input wire logic long_sync,
  input wire logic [2:0] count_code,
  input wire logic [15:0] tx_word,
  // Resolved pins
  input wire logic bclk,
  input wire logic fsync,
  input wire logic dout,
  input wire logic dout_oe,
  // Model drive
  output logic bclk_m,
  output logic fsync_m,
  output logic din,
  // Last completed frame
  output logic [3:0][15:0] cap_f,
  output logic [3:0] drv_f,
  output int sync_len,
  output int nfr
);
  int nbits;
  int fc;
  int pos;
  int hi;
  logic fs_prev;
  logic [3:0][15:0] cap;
  logic [3:0] drv;
  logic oe_h;

  assign nbits = 16 << count_code;
  // Enable seen 1 ns late: the design may release it at the falling edge
  assign #1 oe_h = dout_oe;

  initial begin
    bclk_m = 1'b0;
    fsync_m = 1'b0;
    din = 1'b0;
    cap_f = '0;
    drv_f = '0;
    sync_len = 0;
    nfr = 0;
    fc = 0;
    pos = 1000;
    hi = 0;
    fs_prev = 1'b0;
    cap = '0;
    drv = '0;
  end

  // Bit clock runs only while the model is bus master
  always begin
    #40;
    if (gen) bclk_m = ~bclk_m;
    else bclk_m = 1'b0;
  end

  always @(posedge bclk_m) begin
    fc = (fc + 1) % nbits;
    if (long_sync) fsync_m = (fc < 3);
    else fsync_m = (fc == nbits - 1);
  end

  // Same word in every slot except a long-sync frame's first bit; inverse of last bit there and outside the frame
  always @(posedge bclk) begin
    pos = pos + 1;
    if (pos >= 0 && pos < nbits) din = tx_word[15 - pos % 16];
    else din = ~din;
  end

  // Last bit of a frame is taken before the sync closes the frame
  always @(negedge bclk) begin
    if (pos >= 0 && pos < nbits && oe_h) begin
      cap[pos / 16][15 - pos % 16] = dout;
      drv[pos / 16] = 1'b1;
    end
    if (fsync) hi = hi + 1;
    else if (hi != 0) begin
      sync_len = hi;
      hi = 0;
    end
    if (fsync && !fs_prev) begin
      cap_f = cap;
      drv_f = drv;
      nfr = nfr + 1;
      cap = '0;
      drv = '0;
      pos = long_sync ? 0 : -1;
      if (long_sync && oe_h) begin
        cap[0][15] = dout;
        drv[0] = 1'b1;
      end
    end
    fs_prev = fsync;
  end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the PCM voice slot interface
`timescale 1ns/10ps
module tb_top;
  logic clock;
  logic rst_n;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  logic [31:0] fmt;
  logic reg_wr;
  logic reg_rd;
  logic bclk_o, bclk_oe, fsync_o, fsync_oe, dout_o, dout_oe;
  logic bclk_m, fsync_m, din_m, bclk_w, fsync_w;
  logic gen, long_m;
  logic [15:0] tx_m, smp;
  logic [3:0][15:0] cap_f;
  logic [3:0] drv_f;
  int sync_len, nfr, miscompares, compares, cyc, seed;
  logic [31:0] ctrl_t [11];
  logic [1:0] fill_t [11];
  logic [3:0] ra_t [7];
  logic [31:0] rx_t [7];

  assign bclk_w = bclk_oe ? bclk_o : bclk_m;
  assign fsync_w = fsync_oe ? fsync_o : fsync_m;

  pvs_pcm_slot pvs_pcm_slot_inst (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bclk_i(bclk_w), .bclk_o(bclk_o),
    .bclk_oe(bclk_oe), .fsync_i(fsync_w), .fsync_o(fsync_o),
    .fsync_oe(fsync_oe), .din_i(din_m), .dout_o(dout_o),
    .dout_oe(dout_oe)
  );

  pvs_codec_model pvs_codec_model_inst (
    .gen(gen), .long_sync(long_m), .count_code(3'h1), .tx_word(tx_m),
    .bclk(bclk_w), .fsync(fsync_w), .dout(dout_o), .dout_oe(dout_oe),
    .bclk_m(bclk_m), .fsync_m(fsync_m), .din(din_m), .cap_f(cap_f),
    .drv_f(drv_f), .sync_len(sync_len), .nfr(nfr)
  );

  always #5 clock = ~clock;

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_fr(input int n);
    int s;
    int k;
    s = nfr;
    k = 0;
    while (nfr < s + n && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (nfr < s + n) begin
      miscompares++;
      end_sim;
    end
  endtask

  function automatic logic [15:0] rev16(input logic [15:0] w);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = w[15 - i];
    return r;
  endfunction

  // Word seen on the wire, first bit in the top position
  function automatic logic [15:0] exp_tx(input logic [31:0] c,
      input logic [4:0] f, input logic [15:0] s);
    logic [2:0] fl;
    logic [15:0] w;
    case (f[1:0])
      2'h0: fl = 3'h0;
      2'h1: fl = 3'h7;
      2'h2: fl = {3{s[12]}};
      default: fl = f[4:2];
    endcase
    if (c[7:6] != 2'h0) w = s;
    else if (c[5]) w = {fl, s[12:0]};
    else w = {s[12:0], fl};
    return c[4] ? rev16(w) : w;
  endfunction

  function automatic logic [15:0] exp_rx(input logic [31:0] c,
      input logic [15:0] m);
    logic [15:0] w;
    logic [12:0] v;
    w = c[4] ? rev16(m) : m;
    v = c[5] ? w[12:0] : w[15:3];
    return (c[7:6] != 2'h0) ? w : {{3{v[12]}}, v};
  endfunction

  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_sim;
    end
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gen = 1'b0;
    long_m = 1'b0;
    tx_m = 16'h0;
    miscompares = 0;
    compares = 0;
    cyc = 0;
    seed = 14;
    ctrl_t = '{32'h103, 32'h103, 32'h103, 32'h103, 32'h133, 32'h10B,
               32'h143, 32'h183, 32'h107, 32'h101, 32'h105};
    fill_t = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0,
               2'h1, 2'h3};
    ra_t = '{pvs_pkg::ADDR_CTRL, pvs_pkg::ADDR_SLOT, pvs_pkg::ADDR_FMT,
             pvs_pkg::ADDR_DIV, pvs_pkg::ADDR_RX0, pvs_pkg::ADDR_STAT,
             4'hF};
    rx_t = '{32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // Read-only and unmapped places ignore writes
    wr(pvs_pkg::ADDR_RX0, 32'hFFFF_FFFF);
    wr(4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++) begin
      rd(ra_t[i], rv);
      chk(rv, rx_t[i]);
    end
    chk({29'h0, bclk_oe, fsync_oe, dout_oe}, 32'h0);
    for (int i = 0; i < 11; i++) begin
      fmt = {27'h0, 3'($random(seed)), fill_t[i]};
      smp = 16'($random(seed));
      wr(pvs_pkg::ADDR_CTRL, 32'h0);
      wr(pvs_pkg::ADDR_STAT, 32'h3F);
      gen <= ~ctrl_t[i][1];
      long_m <= ctrl_t[i][2];
      tx_m <= 16'($random(seed));
      wr(pvs_pkg::ADDR_SLOT, 32'h49);
      wr(pvs_pkg::ADDR_FMT, fmt);
      wr(pvs_pkg::ADDR_TX0, {16'h0, smp});
      rd(pvs_pkg::ADDR_SLOT, rv);
      chk(rv, 32'h49);
      rd(pvs_pkg::ADDR_STAT, rv);
      chk({26'h0, rv[5:0]}, 32'h0);
      wr(pvs_pkg::ADDR_CTRL, ctrl_t[i]);
      wait_fr(3);
      smp = exp_tx(ctrl_t[i], fmt[4:0], smp);
      chk({16'h0, cap_f[1]}, {16'h0, smp});
      chk({28'h0, drv_f}, 32'h2);
      chk(32'(sync_len), ctrl_t[i][2] ? 32'h3 : 32'h1);
      chk({30'h0, bclk_oe, fsync_oe}, ctrl_t[i][1] ? 32'h3 : 32'h0);
      rd(pvs_pkg::ADDR_RX0, rv);
      smp = exp_rx(ctrl_t[i], tx_m);
      chk({16'h0, rv[15:0]}, {16'h0, smp});
      rd(pvs_pkg::ADDR_STAT, rv);
      chk({26'h0, rv[5:0] & 6'h09}, 32'h9);
    end
    end_sim;
  end
endmodule
